// ===== hw/iiu_decode.sv
// instruction pattern decoder for the two increment instructions
`timescale 1ns/1ps
module iiu_decode
   import iiu_pkg::*;
(
   input wire logic [11:0] instr,
   output logic is_inc,
   output logic is_incskip,
   output logic dest_reg,
   output logic [4:0] addr
);
   always_comb begin
      is_inc = instr[IIU_OPC_MSB:IIU_OPC_LSB] == IIU_OPC_INC;
      is_incskip = instr[IIU_OPC_MSB:IIU_OPC_LSB] == IIU_OPC_INCSKIP;
      dest_reg = instr[IIU_DEST_POS];
      addr = instr[IIU_ADDR_MSB:IIU_ADDR_LSB];
   end
endmodule

// ===== hw/iiu_pkg.sv
// constants and types for the increment instruction unit
package iiu_pkg;
   // ==========================================
   // instruction word layout
   localparam int IIU_INSTR_W = 12;
   localparam int IIU_DATA_W = 8;
   localparam int IIU_ADDR_W = 5;
   localparam int IIU_OPC_MSB = 11;
   localparam int IIU_OPC_LSB = 6;
   localparam int IIU_DEST_POS = 5;
   localparam int IIU_ADDR_MSB = 4;
   localparam int IIU_ADDR_LSB = 0;
   localparam logic [5:0] IIU_OPC_INC = 6'h0A;
   localparam logic [5:0] IIU_OPC_INCSKIP = 6'h0F;
   localparam logic IIU_DEST_ACC = 1'b0;
   localparam logic IIU_DEST_REG = 1'b1;
   // ==========================================
   // reset values and the increment constant
   localparam logic [7:0] IIU_DATA_RST = 8'h00;
   localparam logic [4:0] IIU_ADDR_RST = 5'h00;
   localparam logic [7:0] IIU_ONE = 8'h01;
   // ==========================================
   // sequencing states
   typedef enum logic [1:0] {
      IIU_IDLE = 2'b00,
      IIU_EXEC = 2'b01,
      IIU_NOP = 2'b10
   } iiu_state_t;
endpackage

// ===== hw/iiu_top.sv
// increment and increment-skip execution unit
// Function
// - increment_register pattern: add one to register f, set zero flag.
// - increment_skip_if_null: add one, keep flags, skip next when zero.
// - destination bit 0: result to accumulator, register untouched.
// - destination bit 1: result written back to the same register.
// - on zero skip, the already-fetched next instruction is discarded.
// - discarded slot runs a no_operation cycle; two cycles on a skip.
`timescale 1ns/1ps
module iiu_top
   import iiu_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [11:0] instr,
   input wire logic [7:0] rf_rdata,
   output logic [4:0] rf_raddr,
   output logic rf_we,
   output logic [4:0] rf_waddr,
   output logic [7:0] rf_wdata,
   output logic acc_we,
   output logic [7:0] acc_wdata,
   output logic zero_we,
   output logic zero_val,
   output logic discard_next,
   output logic nop_cycle,
   output logic busy
);
   // ==========================================
   // decode
   logic dec_inc;
   logic dec_skip;
   logic dec_dest;
   logic [4:0] dec_addr;

   iiu_decode u_dec (
      .instr(instr),
      .is_inc(dec_inc),
      .is_incskip(dec_skip),
      .dest_reg(dec_dest),
      .addr(dec_addr)
   );

   function automatic logic [7:0] iiu_incr(input logic [7:0] v);
      iiu_incr = v + IIU_ONE;
   endfunction

   // an all-ones operand wraps to a null result
   function automatic logic iiu_is_null(input logic [7:0] v);
      iiu_is_null = (v == IIU_DATA_RST);
   endfunction

   // ==========================================
   // sequencing state
   iiu_state_t state_reg, state_next;
   logic skip_reg, skip_next;
   logic dest_reg, dest_next;
   logic [4:0] addr_reg, addr_next;
   logic [4:0] rf_raddr_reg, rf_raddr_next;
   logic rf_we_reg, rf_we_next;
   logic [4:0] rf_waddr_reg, rf_waddr_next;
   logic [7:0] rf_wdata_reg, rf_wdata_next;
   logic acc_we_reg, acc_we_next;
   logic [7:0] acc_wdata_reg, acc_wdata_next;
   logic zero_we_reg, zero_we_next;
   logic zero_val_reg, zero_val_next;
   logic discard_reg, discard_next_v;
   logic nop_reg, nop_next;
   logic busy_reg, busy_next;
   logic [7:0] result;
   logic result_null;
   logic take;
   logic skip_hit;

   // one adder serves both instructions; its zero test also steers the skip
   assign result = iiu_incr(rf_rdata);
   assign result_null = iiu_is_null(result);
   // words offered while busy are not looked at, and nothing says so
   assign take = (state_reg == IIU_IDLE) && instr_valid
      && (dec_inc || dec_skip);
   // skip only on a null result
   assign skip_hit = (state_reg == IIU_EXEC) && skip_reg && result_null;

   // ==========================================
   // instruction sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IIU_IDLE: begin
            if (take) begin
               state_next = IIU_EXEC;
            end
         end
         IIU_EXEC: begin
            if (skip_hit) begin
               state_next = IIU_NOP;
            end else begin
               state_next = IIU_IDLE;
            end
         end
         IIU_NOP: begin
            state_next = IIU_IDLE;
         end
         default: begin
            state_next = IIU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= IIU_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // operand capture
   always_comb begin
      skip_next = skip_reg;
      dest_next = dest_reg;
      addr_next = addr_reg;
      rf_raddr_next = rf_raddr_reg;
      if (take) begin
         // address goes out next cycle, read data settles before the edge that ends EXEC
         skip_next = dec_skip;
         dest_next = dec_dest;
         addr_next = dec_addr;
         rf_raddr_next = dec_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         skip_reg <= 1'b0;
         dest_reg <= IIU_DEST_ACC;
         addr_reg <= IIU_ADDR_RST;
         rf_raddr_reg <= IIU_ADDR_RST;
      end else if (ce) begin
         skip_reg <= skip_next;
         dest_reg <= dest_next;
         addr_reg <= addr_next;
         rf_raddr_reg <= rf_raddr_next;
      end
   end

   // ==========================================
   // strobes towards the fetch pipeline
   always_comb begin
      busy_next = take;
      discard_next_v = 1'b0;
      nop_next = 1'b0;
      if (skip_hit) begin
         discard_next_v = 1'b1;
         busy_next = 1'b1;
      end
      // dead cycle in place of the dropped word
      if (state_reg == IIU_NOP) begin
         nop_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         discard_reg <= 1'b0;
         nop_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (ce) begin
         discard_reg <= discard_next_v;
         nop_reg <= nop_next;
         busy_reg <= busy_next;
      end
   end

   // ==========================================
   // result stage
   // ce low holds these strobes too, so the partner must stall alongside
   always_comb begin
      rf_we_next = 1'b0;
      rf_waddr_next = rf_waddr_reg;
      rf_wdata_next = rf_wdata_reg;
      acc_we_next = 1'b0;
      acc_wdata_next = acc_wdata_reg;
      zero_we_next = 1'b0;
      zero_val_next = zero_val_reg;
      if (state_reg == IIU_EXEC) begin
         if (dest_reg == IIU_DEST_REG) begin
            rf_we_next = 1'b1;
            rf_waddr_next = addr_reg;
            rf_wdata_next = result;
         end else begin
            acc_we_next = 1'b1;
            acc_wdata_next = result;
         end
         // zero flag only for plain increment
         if (!skip_reg) begin
            zero_we_next = 1'b1;
            zero_val_next = result_null;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rf_we_reg <= 1'b0;
         rf_waddr_reg <= IIU_ADDR_RST;
         rf_wdata_reg <= IIU_DATA_RST;
         acc_we_reg <= 1'b0;
         acc_wdata_reg <= IIU_DATA_RST;
         zero_we_reg <= 1'b0;
         zero_val_reg <= 1'b0;
      end else if (ce) begin
         rf_we_reg <= rf_we_next;
         rf_waddr_reg <= rf_waddr_next;
         rf_wdata_reg <= rf_wdata_next;
         acc_we_reg <= acc_we_next;
         acc_wdata_reg <= acc_wdata_next;
         zero_we_reg <= zero_we_next;
         zero_val_reg <= zero_val_next;
      end
   end

   assign rf_raddr = rf_raddr_reg;
   assign rf_we = rf_we_reg;
   assign rf_waddr = rf_waddr_reg;
   assign rf_wdata = rf_wdata_reg;
   assign acc_we = acc_we_reg;
   assign acc_wdata = acc_wdata_reg;
   assign zero_we = zero_we_reg;
   assign zero_val = zero_val_reg;
   assign discard_next = discard_reg;
   assign nop_cycle = nop_reg;
   assign busy = busy_reg;
endmodule

// ===== testbench/iiu_rf_model.sv
// register file model on the far side of the unit
`timescale 1ns/1ps
module iiu_rf_model (
   input wire logic clk,
   input wire logic ce,
   input wire logic rf_we,
   input wire logic [4:0] rf_raddr,
   input wire logic [4:0] rf_waddr,
   input wire logic [7:0] rf_wdata,
   output logic [7:0] rf_rdata
);
   logic [7:0] mem [32];
   // plain always: the bench presets cells too
   assign rf_rdata = mem[rf_raddr];
   always @(posedge clk) begin
      // the core stalls with the unit, so a held strobe writes once
      if (ce && rf_we) begin
         mem[rf_waddr] <= rf_wdata;
      end
   end
endmodule

// ===== testbench/iiu_top_assertions.sv
// assertions for the increment instruction unit
`timescale 1ns/1ps
module iiu_chk
   import iiu_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic rf_we,
   input wire logic acc_we,
   input wire logic zero_we,
   input wire logic zero_val,
   input wire logic discard_next,
   input wire logic nop_cycle,
   input wire logic busy,
   input wire logic [4:0] rf_raddr,
   input wire logic [4:0] rf_waddr,
   input wire logic [7:0] rf_rdata,
   input wire logic [7:0] rf_wdata,
   input wire logic [7:0] acc_wdata
);
   default clocking @(posedge clk); endclocking
   // a frozen cycle holds strobes up with nothing new behind them
   default disable iff (!resetn || !ce);
   // ==========================================
   // data read one enabled cycle before the strobe
   chk_reg_sum: assert property (
      $past(ce) && rf_we |-> rf_wdata == $past(rf_rdata) + IIU_ONE)
      else $error("bad register sum");
   chk_acc_sum: assert property (
      $past(ce) && acc_we |-> acc_wdata == $past(rf_rdata) + IIU_ONE)
      else $error("bad accumulator sum");
   chk_same_reg: assert property (
      rf_we |-> rf_waddr == rf_raddr)
      else $error("write to other register");
   chk_zero_flag: assert property (
      $past(ce) && zero_we |-> (rf_we || acc_we)
         && zero_val == ($past(rf_rdata) == 8'hFF))
      else $error("bad zero flag");
   chk_skip_flags: assert property (
      discard_next |-> !zero_we)
      else $error("flag touched by skip");
   chk_skip_cause: assert property (
      $past(ce) && discard_next |-> (rf_we || acc_we)
         && $past(rf_rdata) == 8'hFF)
      else $error("bad discard");
   chk_nop_slot: assert property (
      discard_next |=> nop_cycle && !rf_we && !acc_we)
      else $error("no idle slot");
   chk_one_cycle: assert property (
      $rose(busy) |-> ##1 (rf_we || acc_we))
      else $error("result late");
   cover property (discard_next);
   cover property (zero_we && zero_val);
   cover property (acc_we);
endmodule
bind iiu_top iiu_chk chk (
   .clk(clk),
   .resetn(resetn),
   .ce(ce),
   .rf_we(rf_we),
   .acc_we(acc_we),
   .zero_we(zero_we),
   .zero_val(zero_val),
   .discard_next(discard_next),
   .nop_cycle(nop_cycle),
   .busy(busy),
   .rf_raddr(rf_raddr),
   .rf_waddr(rf_waddr),
   .rf_rdata(rf_rdata),
   .rf_wdata(rf_wdata),
   .acc_wdata(acc_wdata)
);

// ===== testbench/tb_increment_instruction_unit.sv
// testbench for the increment instruction unit
`timescale 1ns/1ps
module tb_increment_instruction_unit;
   import iiu_pkg::*;
   logic clk, resetn, ce, instr_valid, rf_we, acc_we, zero_we, zero_val;
   logic discard_next, nop_cycle, busy;
   logic [11:0] instr;
   logic [4:0] rf_raddr, rf_waddr;
   logic [7:0] rf_rdata, rf_wdata, acc_wdata;
   int n_errors, total_checks;
   iiu_top uut (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .instr_valid(instr_valid),
      .instr(instr),
      .rf_rdata(rf_rdata),
      .rf_raddr(rf_raddr),
      .rf_we(rf_we),
      .rf_waddr(rf_waddr),
      .rf_wdata(rf_wdata),
      .acc_we(acc_we),
      .acc_wdata(acc_wdata),
      .zero_we(zero_we),
      .zero_val(zero_val),
      .discard_next(discard_next),
      .nop_cycle(nop_cycle),
      .busy(busy)
   );
   iiu_rf_model rf (
      .clk(clk),
      .ce(ce),
      .rf_we(rf_we),
      .rf_raddr(rf_raddr),
      .rf_waddr(rf_waddr),
      .rf_wdata(rf_wdata),
      .rf_rdata(rf_rdata)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      chk_v({7'h00, g}, {7'h00, e});
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] exp_sum(input logic [7:0] v);
      exp_sum = v + IIU_ONE;
   endfunction
   function automatic logic exp_skip(input logic [5:0] op,
                                     input logic [7:0] v);
      exp_skip = (op == IIU_OPC_INCSKIP) && (exp_sum(v) == 8'h00);
   endfunction
   // ==========================================
   // one instruction, fixed latency; st frozen cycles after the take
   task automatic run(input logic [5:0] op, input logic d,
                      input logic [4:0] f, input logic [7:0] v,
                      input int st);
      logic hit, inc, sk;
      logic [7:0] r;
      inc = (op == IIU_OPC_INC);
      hit = inc || (op == IIU_OPC_INCSKIP);
      r = exp_sum(v);
      sk = exp_skip(op, v);
      rf.mem[f] = v;
      instr_valid = 1'b1;
      instr = {op, d, f};
      @(negedge clk);
      instr_valid = 1'b0;
      chk_b(busy, hit);
      if (st > 0) begin
         ce = 1'b0;
         repeat (st) @(negedge clk);
         chk_b(busy, hit);
         chk_b(rf_we || acc_we, 1'b0);
         ce = 1'b1;
      end
      @(negedge clk);
      chk_b(rf_we, hit && d);
      chk_b(acc_we, hit && !d);
      if (hit) chk_v(d ? rf_wdata : acc_wdata, r);
      chk_b(zero_we, hit && inc);
      if (hit && inc) chk_b(zero_val, r == 8'h00);
      chk_b(discard_next, sk);
      chk_b(busy, sk);
      @(negedge clk);
      chk_b(nop_cycle, sk);
      chk_b(busy, 1'b0);
      chk_v(rf.mem[f], (hit && d) ? r : v);
      @(negedge clk);
   endtask
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      instr_valid = 1'b0;
      instr = 12'h000;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(32'hA6BBCE11));
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      run(IIU_OPC_INC, 1'b1, 5'h1F, 8'hFF, 0);
      run(IIU_OPC_INCSKIP, 1'b0, 5'h00, 8'hFF, 0);
      run(IIU_OPC_INCSKIP, 1'b1, 5'h03, 8'hFF, 2);
      run(IIU_OPC_INC, 1'b0, 5'h07, 8'h7F, 1);
      run(6'h0B, 1'b1, 5'h02, 8'hFF, 0);
      run(IIU_OPC_INCSKIP, 1'b1, 5'h09, 8'h41, 0);
      // reset lands while an instruction is in flight
      instr_valid = 1'b1;
      instr = {IIU_OPC_INC, IIU_DEST_REG, 5'h04};
      @(negedge clk);
      instr_valid = 1'b0;
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      chk_b(busy, 1'b0);
      chk_b(rf_we, 1'b0);
      resetn = 1'b1;
      repeat (60) begin
         run($urandom_range(1) ? IIU_OPC_INC : IIU_OPC_INCSKIP,
             1'($urandom), 5'($urandom),
             8'($urandom) | {8{$urandom_range(3) == 0}},
             ($urandom_range(5) == 0) ? 2 : 0);
      end
      summarize;
   end
endmodule
